// File: core/spi_flash_power_down_control.sv
`timescale 1ns/1ps
// Operation
// - in deep sleep only resume and the reset pair act; others ignored
// - resume: standby gives id, deep wakes with id, ultra wakes without id
// - eight-bit resume then release wakes deep sleep within deep wake time
// - host holds select for 24 dummy clocks then 8 id clocks
// - id byte goes out msb first, repeating while select stays low
// - release after resume in ultra sleep resets, clears volatile, wakes
// - release before full command or off byte boundary aborts resume
// - ultra sleep entered by ultra command or deep command with depth bit clear
// - in ultra sleep every command but resume is ignored
// - ultra command enters ultra sleep after release; extra whole bytes ignored
// - release off byte boundary during ultra command stays in standby
// - ultra command ignored while busy; host polls and reissues
// - deep command with depth bit set enters deep sleep on release
module spi_flash_power_down_control
    import spi_pd_pkg::*;
#(
    parameter logic [7:0] DEVICE_ID = 8'h5A, // arbitrary value
    parameter int DEEP_WAKE_TIME_NS = 3000,
    parameter int ULTRA_WAKE_TIME_NS = 100000,
    parameter int ULTRA_ENTRY_TIME_NS = 3000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic busy_flag,
    input wire logic sleep_depth_select,
    output logic so,
    output logic so_oe,
    output power_mode_t power_mode,
    output logic ready,
    output logic other_cmds_enabled,
    output logic reset_pair_enabled,
    output logic internal_reset
);

    // longest times round down, never below one cycle
    localparam int DEEP_WAKE_CYC = (DEEP_WAKE_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 :
        DEEP_WAKE_TIME_NS / CLOCK_PERIOD_NS;
    localparam int ULTRA_WAKE_CYC = (ULTRA_WAKE_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 :
        ULTRA_WAKE_TIME_NS / CLOCK_PERIOD_NS;
    localparam int ULTRA_ENTRY_CYC = (ULTRA_ENTRY_TIME_NS / CLOCK_PERIOD_NS < 1) ? 1 :
        ULTRA_ENTRY_TIME_NS / CLOCK_PERIOD_NS;
    localparam logic [TIMER_W-1:0] DEEP_WAKE_LOAD = TIMER_W'(DEEP_WAKE_CYC - 1);
    localparam logic [TIMER_W-1:0] ULTRA_WAKE_LOAD = TIMER_W'(ULTRA_WAKE_CYC - 1);
    localparam logic [TIMER_W-1:0] ULTRA_ENTRY_LOAD = TIMER_W'(ULTRA_ENTRY_CYC - 1);
    localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
    localparam logic [TIMER_W-1:0] TIMER_ONE = {{(TIMER_W-1){1'b0}}, 1'b1};

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_d;
        logic sck_s1;
        logic sck_s2;
        logic sck_d;
        logic si_s1;
        logic si_s2;
        logic [5:0] cnt;
        logic [7:0] shift;
        logic [7:0] cmd;
        pd_state_t state;
        logic [TIMER_W-1:0] timer;
        logic armed;
        logic so;
        logic so_oe;
        logic internal_reset;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{
        cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
        sck_s1: 1'b0, sck_s2: 1'b0, sck_d: 1'b0,
        si_s1: 1'b0, si_s2: 1'b0,
        cnt: CNT_ZERO, shift: CMD_NONE, cmd: CMD_NONE,
        state: st_standby, timer: TIMER_ZERO, armed: 1'b0,
        so: 1'b0, so_oe: 1'b0, internal_reset: 1'b0
    };

    ctrl_t cur;
    ctrl_t next_cur;

    logic sck_rise;
    logic sck_fall;
    logic release_cs;
    logic start_cs;
    logic aligned;
    logic id_active;

    assign sck_rise = cur.sck_s2 & ~cur.sck_d;
    assign sck_fall = ~cur.sck_s2 & cur.sck_d;
    assign release_cs = cur.cs_s2 & ~cur.cs_d;
    assign start_cs = ~cur.cs_s2 & cur.cs_d;
    // whole command and a whole number of bytes
    assign aligned = (cur.cnt[2:0] == BYTE_POS_ZERO) && (cur.cnt != CNT_ZERO);
    // no identifier out of ultra sleep
    assign id_active = ~cur.cs_s2 && (cur.cmd == CMD_RESUME) && (cur.cnt >= ID_FIRST)
        && (cur.state == st_standby || cur.state == st_deep);

    // ***********************************
    // next state
    // ***********************************
    always_comb begin
        next_cur = cur;
        if (enable) begin
            next_cur.cs_s1 = cs_n;
            next_cur.cs_s2 = cur.cs_s1;
            next_cur.cs_d = cur.cs_s2;
            next_cur.sck_s1 = sck;
            next_cur.sck_s2 = cur.sck_s1;
            next_cur.sck_d = cur.sck_s2;
            next_cur.si_s1 = si;
            next_cur.si_s2 = cur.si_s1;
            next_cur.internal_reset = 1'b0;

            if (start_cs) begin
                next_cur.cnt = CNT_ZERO;
                next_cur.cmd = CMD_NONE;
            end else if (~cur.cs_s2) begin
                if (sck_rise) begin
                    next_cur.shift = {cur.shift[6:0], cur.si_s2};
                    // id phase wraps so the byte repeats
                    next_cur.cnt = (cur.cnt == ID_LAST) ? ID_FIRST : cur.cnt + CNT_ONE;
                    if (cur.cnt == CMD_LAST_BIT) begin
                        next_cur.cmd = {cur.shift[6:0], cur.si_s2};
                    end
                end
                // drive on falling edge, host samples on the next rising edge
                if (sck_fall && id_active) begin
                    next_cur.so = DEVICE_ID[BIT_MSB - cur.cnt[2:0]];
                    next_cur.so_oe = 1'b1;
                end
            end else begin
                next_cur.so_oe = 1'b0;
            end

            unique case (cur.state)
                st_standby: begin
                    if (release_cs && aligned && !busy_flag) begin
                        if (cur.cmd == CMD_ULTRA) begin
                            next_cur.state = st_enter_ultra;
                            next_cur.timer = ULTRA_ENTRY_LOAD;
                        end else if (cur.cmd == CMD_DEEP) begin
                            if (sleep_depth_select) begin
                                next_cur.state = st_deep;
                            end else begin
                                next_cur.state = st_enter_ultra;
                                next_cur.timer = ULTRA_ENTRY_LOAD;
                            end
                        end
                    end
                end
                st_deep: begin
                    if (release_cs) begin
                        next_cur.armed = 1'b0;
                        if (aligned && cur.cmd == CMD_RESUME) begin
                            next_cur.state = st_wake_deep;
                            next_cur.timer = DEEP_WAKE_LOAD;
                        end else if (aligned && cur.cmd == CMD_RESET_EN) begin
                            next_cur.armed = 1'b1;
                        end else if (aligned && cur.cmd == CMD_RESET && cur.armed) begin
                            next_cur.state = st_standby;
                            next_cur.internal_reset = 1'b1;
                        end
                    end
                end
                st_ultra: begin
                    if (release_cs && aligned && cur.cmd == CMD_RESUME) begin
                        next_cur.state = st_wake_ultra;
                        next_cur.timer = ULTRA_WAKE_LOAD;
                        next_cur.internal_reset = 1'b1;
                    end
                end
                st_enter_ultra, st_wake_deep, st_wake_ultra: begin
                    if (cur.timer == TIMER_ZERO) begin
                        next_cur.state = (cur.state == st_enter_ultra) ? st_ultra : st_standby;
                    end else begin
                        next_cur.timer = cur.timer - TIMER_ONE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cur <= CTRL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign so = cur.so;
    assign so_oe = cur.so_oe;
    assign internal_reset = cur.internal_reset;
    assign ready = (cur.state == st_standby);
    assign other_cmds_enabled = (cur.state == st_standby);
    assign reset_pair_enabled = (cur.state == st_standby) || (cur.state == st_deep);

    always_comb begin
        unique case (cur.state)
            st_deep, st_wake_deep: power_mode = mode_deep;
            st_ultra, st_wake_ultra: power_mode = mode_ultra;
            default: power_mode = mode_standby;
        endcase
    end

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n || !enable);

    sequence s_release_cmd(pd_state_t st, logic [7:0] c);
        release_cs && aligned && cur.state == st && cur.cmd == c;
    endsequence

    sequence s_wake_deep_done;
        cur.state == st_wake_deep && cur.timer == TIMER_ZERO;
    endsequence

    a_deep_ignores_other: assert property (release_cs && cur.state == st_deep
        && cur.cmd != CMD_RESUME && cur.cmd != CMD_RESET |=> cur.state == st_deep)
        else $error("deep sleep left on an ignored command");

    a_id_only_awake: assert property (cur.so_oe |-> cur.cmd == CMD_RESUME
        && cur.state != st_ultra && cur.cnt >= ID_FIRST)
        else $error("identifier driven outside resume from standby or deep");

    a_deep_wake_start: assert property (s_release_cmd(st_deep, CMD_RESUME)
        |=> cur.state == st_wake_deep && cur.timer == DEEP_WAKE_LOAD)
        else $error("resume in deep sleep did not start wake timer");

    a_deep_wake_end: assert property (s_wake_deep_done |=> cur.state == st_standby)
        else $error("deep wake did not end in standby");

    a_id_msb_first: assert property (sck_fall && id_active && cur.cnt == ID_FIRST
        |=> cur.so == DEVICE_ID[7] && cur.so_oe)
        else $error("identifier msb not first");

    a_id_lsb_last: assert property (sck_fall && id_active && cur.cnt == ID_LAST
        |=> cur.so == DEVICE_ID[0])
        else $error("identifier lsb out of place");

    a_ultra_wake_reset: assert property (s_release_cmd(st_ultra, CMD_RESUME)
        |=> internal_reset && cur.state == st_wake_ultra)
        else $error("ultra resume gave no internal reset");

    a_misaligned_abort: assert property (release_cs && !aligned
        && cur.state == st_standby |=> cur.state == st_standby)
        else $error("misaligned release changed mode");

    a_ultra_entry: assert property (s_release_cmd(st_standby, CMD_ULTRA) ##0 !busy_flag
        |=> cur.state == st_enter_ultra ##[1:300] cur.state == st_ultra)
        else $error("ultra command did not enter ultra sleep");

    a_depth_bit_clear: assert property (s_release_cmd(st_standby, CMD_DEEP) ##0 !busy_flag
        && !sleep_depth_select |=> cur.state == st_enter_ultra)
        else $error("deep command with depth bit clear missed ultra sleep");

    a_ultra_ignores: assert property (release_cs && cur.state == st_ultra
        && cur.cmd != CMD_RESUME |=> cur.state == st_ultra)
        else $error("ultra sleep left on an ignored command");

    a_busy_blocks: assert property (release_cs && busy_flag
        && cur.state == st_standby |=> cur.state == st_standby)
        else $error("sleep entered while busy");

    a_deep_entry: assert property (s_release_cmd(st_standby, CMD_DEEP) ##0 !busy_flag
        && sleep_depth_select |=> cur.state == st_deep)
        else $error("deep command with depth bit set missed deep sleep");

    a_mode_on_release: assert property (!release_cs && (cur.state == st_standby
        || cur.state == st_deep || cur.state == st_ultra) |=> $stable(cur.state))
        else $error("power mode changed without a release");

endmodule : spi_flash_power_down_control

// File: core/spi_pd_pkg.sv
package spi_pd_pkg;

    // ***********************************
    // command opcodes
    // ***********************************
    localparam logic [7:0] CMD_RESUME = 8'hAB;
    localparam logic [7:0] CMD_ULTRA = 8'h79;
    localparam logic [7:0] CMD_DEEP = 8'hB9;
    localparam logic [7:0] CMD_RESET_EN = 8'h66;
    localparam logic [7:0] CMD_RESET = 8'h99;
    localparam logic [7:0] CMD_NONE = 8'h00;

    // ***********************************
    // frame bit positions
    // ***********************************
    localparam logic [5:0] CNT_ZERO = 6'h00;
    localparam logic [5:0] CNT_ONE = 6'h01;
    localparam logic [5:0] CMD_LAST_BIT = 6'h07;
    localparam logic [5:0] ID_FIRST = 6'h20;
    localparam logic [5:0] ID_LAST = 6'h27;
    localparam logic [2:0] BYTE_POS_ZERO = 3'h0;
    localparam logic [2:0] BIT_MSB = 3'h7;

    // ***********************************
    // timing
    // ***********************************
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int TIMER_W = 24;

    typedef enum logic [1:0] {
        mode_standby,
        mode_deep,
        mode_ultra
    } power_mode_t;

    typedef enum logic [2:0] {
        st_standby,
        st_deep,
        st_ultra,
        st_enter_ultra,
        st_wake_deep,
        st_wake_ultra
    } pd_state_t;

endpackage : spi_pd_pkg

// File: dv/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clock,
    output logic cs_n,
    output logic sck,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic [15:0] rx;
    logic oe_seen;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        rx = 16'h0000;
        oe_seen = 1'b0;
    end

    // ************************************
    // one frame, mode 0, command then zero bytes
    // ************************************
    // so is read late in the high phase: a slow host, so sync delay cannot race it
    task automatic xfer(input logic [7:0] cmd, input int nclk);
        rx = 16'h0000;
        oe_seen = 1'b0;
        @(negedge clock);
        cs_n = 1'b0;
        for (int i = 0; i < nclk; i++) begin
            si = (i < 8) ? cmd[7 - i] : 1'b0;
            repeat (4) @(negedge clock);
            sck = 1'b1;
            repeat (4) @(negedge clock);
            rx = {rx[14:0], so};
            oe_seen = oe_seen | so_oe;
            sck = 1'b0;
        end
        @(negedge clock);
        cs_n = 1'b1;
        si = ~si; // released line has no pull
        repeat (8) @(negedge clock);
    endtask : xfer
endmodule : spi_host_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    import spi_pd_pkg::*;
    localparam logic [7:0] ID = 8'h5A; // arbitrary value
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic enable = 1'b1;
    logic busy_flag = 1'b0;
    logic sleep_depth_select = 1'b1;
    logic cs_n, sck, si, so, so_oe, ready, other_cmds_enabled, reset_pair_enabled;
    logic internal_reset;
    power_mode_t power_mode;
    int err_total = 0;
    int tests_run = 0;
    int pulses = 0;

    always #25 clock = ~clock;
    always @(posedge clock) if (internal_reset === 1'b1) pulses++;

    spi_host_model u_host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
        .so_oe(so_oe));
    // deep wake long enough to be seen in progress once the host frame ends
    spi_flash_power_down_control #(.DEVICE_ID(ID), .DEEP_WAKE_TIME_NS(500),
        .ULTRA_WAKE_TIME_NS(200),
        .ULTRA_ENTRY_TIME_NS(200)) u_dut (.clock(clock), .rst_n(rst_n), .enable(enable),
        .cs_n(cs_n), .sck(sck), .si(si), .busy_flag(busy_flag),
        .sleep_depth_select(sleep_depth_select), .so(so), .so_oe(so_oe),
        .power_mode(power_mode), .ready(ready), .other_cmds_enabled(other_cmds_enabled),
        .reset_pair_enabled(reset_pair_enabled), .internal_reset(internal_reset));

    // ************************************
    // helpers
    // ************************************
    task automatic send(input logic [7:0] cmd, input int n);
        u_host.xfer(cmd, n);
        repeat (12) @(negedge clock);
    endtask : send

    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // ************************************
    // scenarios
    // ************************************
    task automatic t_reset;
        `CHK("mode", mode_standby, power_mode)
        `CHK("ready", 1'b1, ready)
        `CHK("pair", 1'b1, reset_pair_enabled)
        `CHK("oe", 1'b0, so_oe)
    endtask : t_reset

    task automatic t_standby_id;
        send(CMD_RESUME, 48);
        `CHK("id_rep", {ID, ID}, u_host.rx)
        `CHK("oe_on", 1'b1, u_host.oe_seen)
        `CHK("oe_off", 1'b0, so_oe)
        `CHK("mode", mode_standby, power_mode)
    endtask : t_standby_id

    task automatic t_deep;
        sleep_depth_select = 1'b1;
        send(CMD_DEEP, 8);
        `CHK("mode", mode_deep, power_mode)
        `CHK("others", 1'b0, other_cmds_enabled)
        send(CMD_ULTRA, 8);
        `CHK("mode", mode_deep, power_mode)
        send(CMD_RESUME, 7);
        `CHK("mode", mode_deep, power_mode)
        send(CMD_RESUME, 12);
        `CHK("mode", mode_deep, power_mode)
        u_host.xfer(CMD_RESUME, 8);
        `CHK("ready", 1'b0, ready)
        repeat (12) @(negedge clock);
        `CHK("mode", mode_standby, power_mode)
        send(CMD_DEEP, 8);
        send(CMD_RESUME, 40);
        `CHK("id", ID, u_host.rx[7:0])
        `CHK("mode", mode_standby, power_mode)
    endtask : t_deep

    task automatic t_reset_pair;
        int p0;
        send(CMD_DEEP, 8);
        p0 = pulses;
        send(CMD_RESET_EN, 8);
        send(CMD_RESET, 8);
        `CHK("pulse", p0 + 1, pulses)
        `CHK("mode", mode_standby, power_mode)
    endtask : t_reset_pair

    task automatic t_ultra;
        int p0;
        busy_flag = 1'b1;
        send(CMD_ULTRA, 8);
        `CHK("mode", mode_standby, power_mode)
        busy_flag = 1'b0;
        send(CMD_ULTRA, 16);
        `CHK("mode", mode_ultra, power_mode)
        `CHK("pair", 1'b0, reset_pair_enabled)
        p0 = pulses;
        send(CMD_RESET_EN, 8);
        send(CMD_RESET, 8);
        `CHK("mode", mode_ultra, power_mode)
        send(CMD_RESUME, 40);
        `CHK("no_id", 1'b0, u_host.oe_seen)
        `CHK("pulse", p0 + 1, pulses)
        `CHK("mode", mode_standby, power_mode)
    endtask : t_ultra

    task automatic t_ultra_by_deep;
        sleep_depth_select = 1'b0;
        send(CMD_DEEP, 8);
        `CHK("mode", mode_ultra, power_mode)
        send(CMD_RESUME, 8);
        `CHK("mode", mode_standby, power_mode)
        send(CMD_ULTRA, 12);
        `CHK("mode", mode_standby, power_mode)
    endtask : t_ultra_by_deep

    task automatic t_freeze;
        sleep_depth_select = 1'b1;
        send(CMD_DEEP, 8);
        enable = 1'b0;
        send(CMD_RESUME, 8);
        enable = 1'b1;
        repeat (4) @(negedge clock);
        `CHK("frozen", mode_deep, power_mode)
        send(CMD_RESUME, 8);
        `CHK("mode", mode_standby, power_mode)
    endtask : t_freeze

    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        complete_run();
    end

    initial begin
        repeat (6) @(negedge clock);
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        t_reset();
        t_standby_id();
        t_deep();
        t_reset_pair();
        t_ultra();
        t_ultra_by_deep();
        t_freeze();
        complete_run();
    end
endmodule : tb_top
